// ===== hw/adc_channel_trigger_irq_regs.sv
// The implementer's own choices: the placing of the registers and register access over Avalon-MM.
`include "adc_trig_params.svh"
`timescale 1ns/1ps
`default_nettype none
module adc_channel_trigger_irq_regs #(
  parameter int NUM_CHAN = 22,
  parameter int ADDR_W = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [NUM_CHAN-1:0] resultWrite,
  input wire logic [NUM_CHAN-1:0] bufferRead,
  input wire logic swCommonTrig,
  input wire logic swLevelTrig,
  input wire logic pwmSpecialTrig,
  input wire logic [4:0] pwmPrimaryTrig,
  input wire logic timer1Match,
  input wire logic timer2Match,
  input wire logic pwmSecSpecialTrig,
  input wire logic [4:0] pwmSecondaryTrig,
  input wire logic [1:0] ocTrig,
  input wire logic [4:0] currentLimitTrig,
  input wire logic dedicatedTrig,
  output logic [NUM_CHAN-1:0] convStart,
  output logic [5:0] twoInputMode,
  output logic [5:0] signedOut,
  output logic [NUM_CHAN-1:0] channelIrq,
  output logic commonIrq,
  output logic irq
);
  import adc_trig_pkg::*;

  function automatic reg16_t be_merge(input reg16_t old, input reg16_t nw,
                                      input logic [1:0] be);
    be_merge = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
  endfunction

  function automatic logic [5:0] odd_bits(input reg16_t v);
    odd_bits = {v[11], v[9], v[7], v[5], v[3], v[1]};
  endfunction

  function automatic logic [5:0] even_bits(input reg16_t v);
    even_bits = {v[10], v[8], v[6], v[4], v[2], v[0]};
  endfunction

  function automatic logic is_reserved(input trig_code_t c);
    logic [31:0] rsv;
    rsv = `TRG_RESERVED_SET;
    is_reserved = rsv[c];
  endfunction

  // register state
  logic waitRequest_q;
  logic [31:0] readData_q;
  reg16_t mode_q;
  logic [NUM_CHAN-1:0] ie_q, lvl_q, ready_q, selPrev_q, convStart_q;
  logic [NUM_CHAN-1:0] chanIrq_q;
  logic commonIrq_q, irq_q;
  logic [5:0] twoInput_q, signed_q;
  logic [1:0] irqStat_q, irqMask_q;
  trig_code_t trig_q [0:23];

  // bus decode
  wire logic [7:0] addr8 = 8'(address);
  wire logic reqPending = (read | write) & waitRequest_q;
  wire logic wrDone = write & ~waitRequest_q;
  wire logic rdDone = read & ~waitRequest_q;
  wire reg16_t wdata = writedata[15:0];
  wire logic [1:0] be = byteenable[1:0];
  wire logic [3:0] trigWord = addr8[5:2];
  wire logic trigHit = (addr8[7:6] == 2'b01) && (addr8[1:0] == 2'b00)
                       && (trigWord < `TRIG_REG_COUNT);
  wire logic [4:0] trigIdx = {trigWord, 1'b0};
  wire logic [4:0] trigIdxHi = {trigWord, 1'b1};
  wire logic hitMode = addr8 == `OFF_MODE1_LOW;
  wire logic hitIeL = addr8 == `OFF_IE_LOW;
  wire logic hitIeH = addr8 == `OFF_IE_HIGH;
  wire logic hitRdyL = addr8 == `OFF_RDY_LOW;
  wire logic hitRdyH = addr8 == `OFF_RDY_HIGH;
  wire logic hitLvlL = addr8 == `OFF_LVL_LOW;
  wire logic hitLvlH = addr8 == `OFF_LVL_HIGH;
  wire logic hitStat = addr8 == `OFF_IRQ_STAT;
  wire logic hitMask = addr8 == `OFF_IRQ_MASK;

  // padded channel vectors, 32 wide so both halves slice cleanly
  wire logic [31:0] iePad = 32'(ie_q);
  wire logic [31:0] lvlPad = 32'(lvl_q);
  wire logic [31:0] rdyPad = 32'(ready_q);
  wire reg16_t trigRead = {3'b000, trig_q[trigIdxHi], 3'b000, trig_q[trigIdx]};

  // unmapped and unimplemented bits read as zero
  wire reg16_t rdSel =
    hitMode ? (mode_q & `MODE_IMPL_MASK) :
    hitIeL ? iePad[15:0] :
    hitIeH ? (iePad[31:16] & `HIGH6_MASK) :
    hitRdyL ? rdyPad[15:0] :
    hitRdyH ? (rdyPad[31:16] & `HIGH6_MASK) :
    hitLvlL ? lvlPad[15:0] :
    hitLvlH ? (lvlPad[31:16] & `HIGH6_MASK) :
    hitStat ? 16'(irqStat_q) :
    hitMask ? 16'(irqMask_q) :
    trigHit ? (trigRead & `TRIG_IMPL_MASK) :
    `REG_RESET;

  // write data prepared per register
  wire reg16_t modeNew = be_merge(mode_q, wdata, be) & `MODE_IMPL_MASK;
  wire reg16_t ieLNew = be_merge(iePad[15:0], wdata, be);
  wire reg16_t ieHNew = be_merge(iePad[31:16], wdata, be) & `HIGH6_MASK;
  wire reg16_t lvlLNew = be_merge(lvlPad[15:0], wdata, be);
  wire reg16_t lvlHNew = be_merge(lvlPad[31:16], wdata, be) & `HIGH6_MASK;
  wire reg16_t trigNew = be_merge(trigRead, wdata, be);
  wire trig_code_t trigLoNew = trigNew[4:0];
  wire trig_code_t trigHiNew = trigNew[`TRIG_HI_LSB+4:`TRIG_HI_LSB];
  wire logic wrTrig = wrDone & trigHit;

  // trigger sources indexed by selector code; reserved slots stay low
  wire src_vec_t srcVec = {dedicatedTrig, 2'b00, currentLimitTrig,
                           ocTrig, 2'b00, pwmSecondaryTrig,
                           pwmSecSpecialTrig, timer2Match, timer1Match,
                           2'b00, pwmPrimaryTrig, pwmSpecialTrig,
                           1'b0, swLevelTrig, swCommonTrig, 1'b0};

  // events for the sticky status register
  wire logic resEvent = |(resultWrite & ie_q);
  wire logic rsvEvent = wrTrig & (is_reserved(trigLoNew)
                        | is_reserved(trigHiNew));
  wire logic [1:0] irqEvents = {rsvEvent, resEvent};
  // cleared as the read is taken, so an event after the copy stays pending
  wire logic statClear = read & reqPending & hitStat;
  // set wins over the read clear so no event is lost
  wire logic [1:0] irqStat_d = (statClear ? 2'b00 : irqStat_q) | irqEvents;
  // a new result beats a same-cycle buffer read
  wire logic [NUM_CHAN-1:0] ready_d = (ready_q & ~bufferRead) | resultWrite;

  logic [NUM_CHAN-1:0] selNow, start_d;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CHAN; gi++) begin : g_chan
      assign selNow[gi] = srcVec[trig_q[gi]];
      // edge mode fires once per rising edge of the selected source
      assign start_d[gi] = lvl_q[gi] ? selNow[gi] :
                           (selNow[gi] & ~selPrev_q[gi]);
    end
  endgenerate

  // one wait cycle: answer always lands on the second edge of a request
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      waitRequest_q <= 1'b1;
      readData_q <= 32'h0000_0000;
    end else begin
      waitRequest_q <= ~reqPending;
      if (reqPending && read) begin
        readData_q <= 32'(rdSel);
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= `REG_RESET;
      ie_q <= '0;
      lvl_q <= '0;
      irqMask_q <= 2'b00;
    end else if (wrDone) begin
      if (hitMode) mode_q <= modeNew;
      if (hitIeL) ie_q <= NUM_CHAN'({iePad[31:16], ieLNew});
      if (hitIeH) ie_q <= NUM_CHAN'({ieHNew, iePad[15:0]});
      if (hitLvlL) lvl_q <= NUM_CHAN'({lvlPad[31:16], lvlLNew});
      if (hitLvlH) lvl_q <= NUM_CHAN'({lvlHNew, lvlPad[15:0]});
      if (hitMask) irqMask_q <= be[0] ? wdata[1:0] : irqMask_q;
    end
  end

  // both halves of a pair reload from the merged word
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 24; i++) trig_q[i] <= `TRG_NONE;
    end else if (wrTrig) begin
      trig_q[trigIdx] <= trigLoNew;
      trig_q[trigIdxHi] <= trigHiNew;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ready_q <= '0;
      selPrev_q <= '0;
      convStart_q <= '0;
      chanIrq_q <= '0;
      commonIrq_q <= 1'b0;
      irqStat_q <= 2'b00;
      irq_q <= 1'b0;
      twoInput_q <= 6'h00;
      signed_q <= 6'h00;
    end else begin
      ready_q <= ready_d;
      selPrev_q <= selNow;
      convStart_q <= start_d;
      chanIrq_q <= resultWrite & ie_q;
      commonIrq_q <= resEvent;
      irqStat_q <= irqStat_d;
      irq_q <= |(irqStat_q & irqMask_q);
      twoInput_q <= odd_bits(mode_q);
      signed_q <= even_bits(mode_q);
    end
  end

  assign readdata = readData_q;
  assign waitrequest = waitRequest_q;
  assign convStart = convStart_q;
  assign twoInputMode = twoInput_q;
  assign signedOut = signed_q;
  assign channelIrq = chanIrq_q;
  assign commonIrq = commonIrq_q;
  assign irq = irq_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_mode_write;
    write && !waitRequest_q && hitMode && byteenable[1:0] == 2'b11;
  endsequence

  sequence s_read_taken;
    read && waitRequest_q;
  endsequence

  sequence s_stat_read;
    read && waitRequest_q && hitStat;
  endsequence

  a_diff_mode_follow:
    assert property (s_mode_write |=> ##1
      twoInput_q == odd_bits($past(writedata[15:0], 2)))
    else $error("two-input mode bits do not follow mode write");

  a_sign_mode_follow:
    assert property (s_mode_write |=> ##1
      signed_q == even_bits($past(writedata[15:0], 2)))
    else $error("signed bits do not follow mode write");

  a_mode_top_zero:
    assert property (s_read_taken ##1 (read && hitMode) |->
      readData_q[15:12] == 4'h0)
    else $error("mode register top bits not zero");

  a_chan_irq_gate:
    assert property (resultWrite[0] |=>
      chanIrq_q[0] == $past(ie_q[0]) && commonIrq_q == $past(resEvent))
    else $error("channel interrupt not gated by enable");

  a_high_regs_zero:
    assert property (s_read_taken ##1 (read && (hitIeH || hitRdyH ||
      hitLvlH)) |-> readData_q[15:6] == 10'h000)
    else $error("high register unimplemented bits not zero");

  a_ready_set:
    assert property (resultWrite[0] |=>
      ready_q[0])
    else $error("ready flag not set by new result");

  a_ready_clear:
    assert property (bufferRead[0] && !resultWrite[0] |=> !ready_q[0])
    else $error("ready flag not cleared by buffer read");

  a_trig_gaps_zero:
    assert property (s_read_taken ##1 (read && trigHit) |->
      (readData_q[15:0] & ~`TRIG_IMPL_MASK) == 16'h0000)
    else $error("trigger register gap bits not zero");

  a_no_trig_idle:
    assert property (trig_q[0] == `TRG_NONE |=> !convStart_q[0])
    else $error("untriggered channel started");

  a_level_repeat:
    assert property (lvl_q[0] && selNow[0] |=> convStart_q[0])
    else $error("level trigger did not start conversion");

  a_edge_once:
    assert property (!lvl_q[0] && selNow[0] && selPrev_q[0] |=>
      !convStart_q[0])
    else $error("edge trigger started twice on held source");

  a_irq_raise:
    assert property (resEvent && irqMask_q[`IRQ_BIT_RESULT] &&
      !(wrDone && hitMask) |=> ##1 irq_q)
    else $error("masked-in event did not raise interrupt");

  a_bus_answer:
    assert property ((read || write) && waitRequest_q |=> !waitRequest_q)
    else $error("request not answered after one wait cycle");

  a_ie_low_keeps:
    assert property (wrDone && hitIeL |=>
      ie_q[NUM_CHAN-1:16] == $past(ie_q[NUM_CHAN-1:16]))
    else $error("enable low write changed upper channels");

  a_ie_high_keeps:
    assert property (wrDone && hitIeH |=>
      ie_q[15:0] == $past(ie_q[15:0]))
    else $error("enable high write changed lower channels");

  a_lvl_low_keeps:
    assert property (wrDone && hitLvlL |=>
      lvl_q[NUM_CHAN-1:16] == $past(lvl_q[NUM_CHAN-1:16]))
    else $error("level low write changed upper channels");

  a_lvl_high_keeps:
    assert property (wrDone && hitLvlH |=>
      lvl_q[15:0] == $past(lvl_q[15:0]))
    else $error("level high write changed lower channels");

  a_mode_top_clear:
    assert property (wrDone && hitMode |=> mode_q[15:12] == 4'h0)
    else $error("mode register stored top bits");

  a_result_flag_set:
    assert property (resEvent |=> irqStat_q[`IRQ_BIT_RESULT])
    else $error("enabled result did not set status");

  a_rsv_flag_set:
    assert property (rsvEvent |=> irqStat_q[`IRQ_BIT_RSVD])
    else $error("reserved code write did not set status");

  a_rsv_no_start:
    assert property (is_reserved(trig_q[0]) |=> !convStart_q[0])
    else $error("reserved selector started a conversion");

  a_stat_read_clear:
    assert property (s_stat_read |=> irqStat_q == $past(irqEvents))
    else $error("status read did not clear old bits");

  a_wait_idle_high:
    assert property (!read && !write && waitRequest_q |=> waitRequest_q)
    else $error("waitrequest dropped without a request");

  a_wait_one_cycle:
    assert property (!waitRequest_q |=> waitRequest_q)
    else $error("waitrequest low for more than one cycle");

  a_read_data_hold:
    assert property (!read |=> readData_q == $past(readData_q))
    else $error("read data changed without a read");

  a_ready_hold:
    assert property (!resultWrite[0] && !bufferRead[0] |=>
      ready_q[0] == $past(ready_q[0]))
    else $error("ready flag changed without an event");

  a_ready_wins:
    assert property (resultWrite[0] && bufferRead[0] |=> ready_q[0])
    else $error("buffer read beat a same-cycle result");

  a_trig_write_lands:
    assert property (wrTrig && be == 2'b11 |=>
      trig_q[$past(trigIdx)] == $past(wdata[4:0]))
    else $error("trigger selector write did not land");
endmodule
`default_nettype wire

// ===== common/adc_trig_params.svh
`ifndef ADC_TRIG_PARAMS_SVH
`define ADC_TRIG_PARAMS_SVH

`define OFF_MODE1_LOW 8'h00
`define OFF_IE_LOW 8'h04
`define OFF_IE_HIGH 8'h08
`define OFF_RDY_LOW 8'h0C
`define OFF_RDY_HIGH 8'h10
`define OFF_LVL_LOW 8'h14
`define OFF_LVL_HIGH 8'h18
`define OFF_IRQ_STAT 8'h1C
`define OFF_IRQ_MASK 8'h20
`define OFF_TRIG_BASE 8'h40
`define TRIG_REG_COUNT 4'hC

`define REG_RESET 16'h0000
`define MODE_IMPL_MASK 16'h0FFF
`define HIGH6_MASK 16'h003F
`define TRIG_IMPL_MASK 16'h1F1F
`define TRIG_HI_LSB 8
`define IRQ_IMPL_MASK 16'h0003
`define IRQ_BIT_RESULT 0
`define IRQ_BIT_RSVD 1

`define TRG_NONE 5'h00
`define TRG_COMMON_SW 5'h01
`define TRG_LEVEL_SW 5'h02
`define TRG_PWM_SPECIAL 5'h04
`define TRG_PWM_PRI_BASE 5'h05
`define TRG_TMR1 5'h0C
`define TRG_TMR2 5'h0D
`define TRG_PWM_SEC_SPECIAL 5'h0E
`define TRG_PWM_SEC_BASE 5'h0F
`define TRG_OC1 5'h16
`define TRG_OC2 5'h17
`define TRG_CLIM_BASE 5'h18
`define TRG_DEDICATED 5'h1F
`define TRG_RESERVED_SET 32'h60300C08

`endif

// ===== common/adc_trig_pkg.sv
package adc_trig_pkg;
  typedef logic [4:0] trig_code_t;
  typedef logic [15:0] reg16_t;
  typedef logic [31:0] src_vec_t;
endpackage

// ===== verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // reserved selector codes 3,10,11,20,21,29,30
  localparam logic [31:0] RSV = 32'h60300C08;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [7:0] address = 8'h00;
  logic [31:0] writedata = 32'h00000000;
  logic [31:0] srcv = 32'h00000000;
  logic [3:0] byteenable = 4'h0;
  logic [21:0] resultWrite = 22'h000000;
  logic [21:0] bufferRead = 22'h000000;
  logic [31:0] readdata, q;
  logic waitrequest, commonIrq, irq, e;
  logic [21:0] convStart, channelIrq;
  logic [5:0] twoInputMode, signedOut;
  logic [15:0] d, stat;
  int n_fail = 0;
  int checks = 0;

  always #50 clock = ~clock;

  // source vector bit index equals the selector code that picks it
  adc_channel_trigger_irq_regs uut (
    .clock(clock), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .resultWrite(resultWrite), .bufferRead(bufferRead),
    .swCommonTrig(srcv[1]), .swLevelTrig(srcv[2]),
    .pwmSpecialTrig(srcv[4]), .pwmPrimaryTrig(srcv[9:5]),
    .timer1Match(srcv[12]), .timer2Match(srcv[13]),
    .pwmSecSpecialTrig(srcv[14]), .pwmSecondaryTrig(srcv[19:15]),
    .ocTrig(srcv[23:22]), .currentLimitTrig(srcv[28:24]),
    .dedicatedTrig(srcv[31]), .convStart(convStart),
    .twoInputMode(twoInputMode), .signedOut(signedOut),
    .channelIrq(channelIrq), .commonIrq(commonIrq), .irq(irq)
  );

  task automatic report_and_stop;
    if (n_fail == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] x, g);
    checks++;
    if (g !== x) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, x, g);
    end
  endtask

  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input bit wr, input logic [7:0] a, input logic [15:0] v);
    @(posedge clock);
    address <= a;
    writedata <= {16'h0000, v};
    byteenable <= 4'h3;
    read <= !wr;
    write <= wr;
    // look between edges: the edge itself races the registered answer
    do @(negedge clock); while (waitrequest !== 1'b0);
    @(posedge clock);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [15:0] x);
    bus(1'b0, a, 16'h0000);
    chk($sformatf("reg %h", a), {16'h0000, x}, q);
  endtask

  task automatic pulse(input logic [21:0] w, b);
    @(posedge clock);
    resultWrite <= w;
    bufferRead <= b;
    @(posedge clock);
    resultWrite <= 22'h000000;
    bufferRead <= 22'h000000;
  endtask

  function automatic logic [15:0] msk(input int a);
    if (a == 0) return 16'h0FFF;
    if (a == 4 || a == 8'h14) return 16'hFFFF;
    if (a == 8 || a == 8'h18) return 16'h003F;
    if (a == 8'h20) return 16'h0003;
    if (a >= 8'h40 && a < 8'h70) return 16'h1F1F;
    return 16'h0000;
  endfunction

  // generous bound: the whole run needs under a thousand cycles, the limit is 20000
  initial begin
    #2000000;
    n_fail++;
    report_and_stop();
  end

  initial begin
    stat = 16'h0000;
    void'($urandom(32'h5d76));
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    for (int a = 0; a < 8'h78; a += 4) begin
      rchk(a[7:0], 16'h0000);
    end
    // status is skipped: reading it clears it
    for (int a = 0; a < 8'h74; a += 4) begin
      if (a != 8'h1C) begin
        d = 16'($urandom);
        bus(1'b1, a[7:0], d);
        if (a >= 8'h40 && a < 8'h70 && (RSV[d[4:0]] || RSV[d[12:8]])) begin
          stat[1] = 1'b1;
        end
        rchk(a[7:0], d & msk(a));
        for (int k = 0; k < 6 && a == 0; k++) begin
          chk("diff", d[2*k+1], twoInputMode[k]);
          chk("sign", d[2*k], signedOut[k]);
        end
        bus(1'b1, a[7:0], 16'h0000);
      end
    end
    for (int l = 0; l < 2; l++) begin
      bus(1'b1, 8'h14, l[15:0]);
      for (int c = 0; c < 32; c++) begin
        bus(1'b1, 8'h40, c[15:0]);
        if (RSV[c]) stat[1] = 1'b1;
        e = (c != 0) && !RSV[c];
        @(posedge clock);
        srcv <= 32'h00000001 << c;
        @(posedge clock);
        #1 chk("start", {21'h000000, e}, convStart);
        @(posedge clock);
        srcv <= 32'h00000000;
        #1 chk("start", {21'h000000, e & l[0]}, convStart);
      end
    end
    bus(1'b1, 8'h40, 16'h0000);
    bus(1'b1, 8'h14, 16'h0000);
    bus(1'b1, 8'h04, 16'h0001);
    bus(1'b1, 8'h08, 16'h0020);
    for (int m = 0; m < 2; m++) begin
      bus(1'b1, 8'h20, m[15:0]);
      // same-cycle buffer read on channel 0 loses to the new result
      pulse(22'h200003, 22'h000001);
      #1 chk("chanIrq", 22'h200001, channelIrq);
      chk("commonIrq", 1, commonIrq);
      rchk(8'h0C, 16'h0003);
      rchk(8'h10, 16'h0020);
      chk("irq", m, irq);
      rchk(8'h1C, stat | 16'h0001);
      stat = 16'h0000;
      repeat (2) @(posedge clock);
      #1 chk("irq", 0, irq);
      pulse(22'h000000, 22'h200003);
      rchk(8'h0C, 16'h0000);
      rchk(8'h10, 16'h0000);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
